// [hw/mcuic_pkg.sv]
package mcuic_pkg;

	// ---------------------------------------------------------------
	// Register offsets (printed offsets are not all multiples of four,
	// so each is kept as an index; the byte address is index * 4)
	// ---------------------------------------------------------------
	localparam logic [7:0] CORE_IRQ_CONTROL_IDX       = 8'h0b;
	localparam logic [7:0] CORE_IRQ_CONTROL_ALT_IDX   = 8'h8b;
	localparam logic [7:0] PERIPHERAL_IRQ_REQUEST_IDX = 8'h0c;
	localparam logic [7:0] PERIPHERAL_IRQ_ENABLE_IDX  = 8'h8c;
	localparam logic [7:0] EDGE_CONFIG_IDX            = 8'h81;
	localparam logic [7:0] PIN_CHANGE_SELECT_REG_IDX  = 8'h96;
	localparam logic [7:0] CORE_STATUS_IDX            = 8'hf0;

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int GLOBAL_IRQ_ENABLE_BIT       = 7;
	localparam int PERIPHERAL_GROUP_ENABLE_BIT = 6;
	localparam int TIMER0_IRQ_ENABLE_BIT       = 5;
	localparam int EXT_PIN_IRQ_ENABLE_BIT      = 4;
	localparam int PIN_CHANGE_IRQ_ENABLE_BIT   = 3;
	localparam int TIMER0_OVERFLOW_FLAG_BIT    = 2;
	localparam int EXT_PIN_IRQ_FLAG_BIT        = 1;
	localparam int PIN_CHANGE_FLAG_BIT         = 0;
	localparam int EXT_EDGE_SELECT_BIT         = 6;

	localparam int NV_WRITE_DONE_BIT   = 7;
	localparam int CONVERTER_DONE_BIT  = 6;
	localparam int CAPTURE_COMPARE_BIT = 5;
	localparam int COMPARATOR_BIT      = 3;
	localparam int CLOCK_FAIL_BIT      = 2;
	localparam int TIMER2_MATCH_BIT    = 1;
	localparam int TIMER1_OVERFLOW_BIT = 0;

	// ---------------------------------------------------------------
	// Reset values and masks
	// ---------------------------------------------------------------
	localparam logic [7:0] CORE_IRQ_CONTROL_RST = 8'h00;
	localparam logic [7:0] PERIPH_REQUEST_RST   = 8'h00;
	localparam logic [7:0] PERIPH_ENABLE_RST    = 8'h00;
	localparam logic [7:0] EDGE_CONFIG_RST      = 8'hff;
	localparam logic [7:0] PIN_SELECT_RST       = 8'h00;
	localparam logic [7:0] PERIPH_IMPL_MASK     = 8'hef;
	localparam logic [5:0] PIN_SELECT_MASK      = 6'h3f;
	localparam logic [12:0] IRQ_VECTOR          = 13'h0004;

	// ---------------------------------------------------------------
	// Timing: instruction cycle phases
	// ---------------------------------------------------------------
	localparam int          SYS_CLK_MHZ        = 100;
	localparam int          INSTR_CYCLE_NS     = 200;
	localparam int          PHASE_NS           = INSTR_CYCLE_NS / 4;
	localparam int          PHASE_CYCLES_INT   = (PHASE_NS * SYS_CLK_MHZ + 999) / 1000;
	localparam logic [7:0]  PHASE_CYCLES       = PHASE_CYCLES_INT[7:0];
	localparam logic [1:0]  PHASE_Q1           = 2'h0;
	localparam logic [1:0]  PHASE_Q2           = 2'h1;
	localparam logic [1:0]  PHASE_Q4           = 2'h3;
	localparam logic [1:0]  ENTRY_WAIT_CYCLES  = 2'h2;

	// ---------------------------------------------------------------
	// Types
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		MCUIC_RUN   = 2'b00,
		MCUIC_WAIT  = 2'b01,
		MCUIC_ENTER = 2'b10,
		MCUIC_SLEEP = 2'b11
	} mcuic_mode_t;

	typedef struct packed {
		logic nv_write_done;
		logic converter_done;
		logic capture_compare;
		logic comparator1;
		logic comparator2;
		logic clock_fail;
		logic timer2_match;
		logic timer1_overflow;
		logic timer0_overflow;
	} mcuic_events_t;

	typedef struct packed {
		logic instr_end;
		logic return_from_irq_instr;
		logic sleep_instr;
		logic port_read;
	} mcuic_core_in_t;

endpackage : mcuic_pkg

// [hw/mcuic_top.sv]
// How it works
// - Eleven sources: edge pin, timer0, pin change, comparators, converter, timers, nv, clock, capture
// - Global enable bit 7 set lets unmasked pending requests through; cleared blocks all
// - Reset clears the global enable
// - Return-from-interrupt leaves service and sets global enable again
// - Taking an interrupt clears global enable, pushes return address, jumps to 0004h
// - Edge or pin-change latency is three or four instruction cycles, any instruction; here entry follows the third instruction end, about two to three cycles
// - Flags set by their events regardless of any enable bit
// - Instruction clearing global enable suppresses next-cycle interrupt; request stays pending
// - Peripheral flags at 0Ch, matching enables at 8Ch, same bit positions
// - External pin edge-triggered, polarity by edge select bit 6, sets control bit 1
// - Clearing external pin enable bit 4 stops its flag causing an interrupt
// - Valid enabled edge wakes from Sleep; vectoring only with global enable set
// - External pin flag may set anywhere within phases Q4 to Q1; here it sets in any phase, Q1 to Q4
// - Timer0 overflow sets control bit 2, gated by timer0 enable bit 5
// - Selected port pin change sets control bit 0, gated by enable bit 3
// - Pin change coinciding with Q2 port read may be missed
// - Only the return address is saved on entry, no working or status register
// - Wake with global enable runs the instruction after sleep, then vectors; here entry follows the third instruction end after the wake
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps

module mcuic_top
	import mcuic_pkg::*;
#(
	parameter int PIN_COUNT = 6
) (
	input  wire logic                 clk_sys,
	input  wire logic                 nrst,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [11:0]          paddr,
	input  wire logic [31:0]          pwdata,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	input  wire logic                 ext_irq_pin,
	input  wire logic [PIN_COUNT-1:0] port_pins,
	input  wire mcuic_events_t        periph_events,
	input  wire mcuic_core_in_t       core_in,
	input  wire logic [12:0]          return_pc,
	output logic                      irq_take,
	output logic [12:0]               vector_pc,
	output logic                      push_pc,
	output logic [12:0]               push_value,
	output logic                      wake_core,
	output logic                      core_asleep,
	output logic [1:0]                instr_phase
);

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [7:0]           ctrl;
		logic [7:0]           req;
		logic [7:0]           ena;
		logic [7:0]           edge_cfg;
		logic [PIN_COUNT-1:0] pin_sel;
		logic [1:0]           ext_sync;
		logic                 ext_prev;
		logic [PIN_COUNT-1:0] pin_s1;
		logic [PIN_COUNT-1:0] pin_s2;
		logic [PIN_COUNT-1:0] pin_latch;
		logic [7:0]           ph_cnt;
		logic [1:0]           phase;
		mcuic_mode_t          mode;
		logic [1:0]           wait_cnt;
		logic                 gie_block;
		logic                 wake_pend;
		logic [31:0]          prdata;
		logic                 pready;
		logic                 pslverr;
		logic                 irq_take;
		logic                 push_pc;
		logic [12:0]          push_value;
		logic                 wake_core;
		logic                 asleep;
		logic [12:0]          vector;
		logic [2:0]           sync_armed;
	} mcuic_state_t;

	mcuic_state_t st_r;
	mcuic_state_t st_nxt;

	logic [7:0] reg_idx;
	logic       wr_acc;
	logic       rd_acc;
	logic       ext_edge;
	logic       phase_tick;
	logic       pending;
	logic [7:0] wdat;
	logic [7:0] ctrl_set;
	logic [7:0] req_set;
	logic [PIN_COUNT-1:0] pin_diff;

	assign reg_idx    = paddr[9:2];
	assign wdat       = pwdata[7:0];
	assign wr_acc     = psel && penable && pwrite && !st_r.pready;
	assign rd_acc     = psel && penable && !pwrite && !st_r.pready;
	assign phase_tick = (st_r.ph_cnt == PHASE_CYCLES - 8'h01);

	// ---------------------------------------------------------------
	// Source flags
	// ---------------------------------------------------------------
	always_comb begin
		// edge polarity select
		// Reset values of the pin stages are not pin samples: no false edge
		ext_edge = st_r.sync_armed[2] && (st_r.edge_cfg[EXT_EDGE_SELECT_BIT]
			? (st_r.ext_sync[1] && !st_r.ext_prev)
			: (!st_r.ext_sync[1] && st_r.ext_prev));
		pin_diff = (st_r.pin_s2 ^ st_r.pin_latch) & st_r.pin_sel
			& {PIN_COUNT{st_r.sync_armed[2]}};
		ctrl_set = 8'h00;
		// edge flag accepted in any phase, Q1 to Q4
		if (ext_edge)
			ctrl_set[EXT_PIN_IRQ_FLAG_BIT] = 1'b1;
		if (periph_events.timer0_overflow)
			ctrl_set[TIMER0_OVERFLOW_FLAG_BIT] = 1'b1;
		// change at Q2 read can be lost
		if ((|pin_diff) && !(core_in.port_read && st_r.phase == PHASE_Q2))
			ctrl_set[PIN_CHANGE_FLAG_BIT] = 1'b1;
		req_set = 8'h00;
		req_set[NV_WRITE_DONE_BIT]   = periph_events.nv_write_done;
		req_set[CONVERTER_DONE_BIT]  = periph_events.converter_done;
		req_set[CAPTURE_COMPARE_BIT] = periph_events.capture_compare;
		req_set[COMPARATOR_BIT]      = periph_events.comparator1 | periph_events.comparator2;
		req_set[CLOCK_FAIL_BIT]      = periph_events.clock_fail;
		req_set[TIMER2_MATCH_BIT]    = periph_events.timer2_match;
		req_set[TIMER1_OVERFLOW_BIT] = periph_events.timer1_overflow;
	end

	// ---------------------------------------------------------------
	// Request gating
	// ---------------------------------------------------------------
	always_comb begin
		pending = (st_r.ctrl[EXT_PIN_IRQ_FLAG_BIT] && st_r.ctrl[EXT_PIN_IRQ_ENABLE_BIT])
			|| (st_r.ctrl[TIMER0_OVERFLOW_FLAG_BIT] && st_r.ctrl[TIMER0_IRQ_ENABLE_BIT])
			|| (st_r.ctrl[PIN_CHANGE_FLAG_BIT] && st_r.ctrl[PIN_CHANGE_IRQ_ENABLE_BIT])
			|| (st_r.ctrl[PERIPHERAL_GROUP_ENABLE_BIT] && |(st_r.req & st_r.ena));
	end

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		st_nxt.irq_take  = 1'b0;
		st_nxt.push_pc   = 1'b0;
		st_nxt.wake_core = 1'b0;
		st_nxt.pready    = 1'b0;
		st_nxt.pslverr   = 1'b0;

		// Pins cross into this domain; first stage feeds only the second
		st_nxt.ext_sync = {st_r.ext_sync[0], ext_irq_pin};
		st_nxt.ext_prev = st_r.ext_sync[1];
		st_nxt.pin_s1   = port_pins;
		st_nxt.pin_s2   = st_r.pin_s1;
		st_nxt.pin_latch = st_r.pin_s2;
		st_nxt.sync_armed = {st_r.sync_armed[1:0], 1'b1};

		// Q phase divider
		if (phase_tick) begin
			st_nxt.ph_cnt = 8'h00;
			st_nxt.phase  = st_r.phase + 2'h1;
		end else begin
			st_nxt.ph_cnt = st_r.ph_cnt + 8'h01;
		end

		// APB register access, one wait state
		if (rd_acc) begin
			st_nxt.pready = 1'b1;
			st_nxt.prdata = 32'h0000_0000;
			unique case (reg_idx)
				CORE_IRQ_CONTROL_IDX, CORE_IRQ_CONTROL_ALT_IDX:
					st_nxt.prdata[7:0] = st_r.ctrl;
				PERIPHERAL_IRQ_REQUEST_IDX: st_nxt.prdata[7:0] = st_r.req;
				PERIPHERAL_IRQ_ENABLE_IDX:  st_nxt.prdata[7:0] = st_r.ena;
				EDGE_CONFIG_IDX:            st_nxt.prdata[7:0] = st_r.edge_cfg;
				PIN_CHANGE_SELECT_REG_IDX:
					st_nxt.prdata[PIN_COUNT-1:0] = st_r.pin_sel;
				CORE_STATUS_IDX:
					st_nxt.prdata[3:0] = {pending, st_r.wake_pend, st_r.mode};
				default: st_nxt.pslverr = 1'b1;
			endcase
		end else if (wr_acc) begin
			st_nxt.pready = 1'b1;
			unique case (reg_idx)
				CORE_IRQ_CONTROL_IDX, CORE_IRQ_CONTROL_ALT_IDX: begin
					st_nxt.ctrl = wdat;
					if (!wdat[GLOBAL_IRQ_ENABLE_BIT])
						st_nxt.gie_block = 1'b1;
				end
				PERIPHERAL_IRQ_REQUEST_IDX: st_nxt.req = wdat & PERIPH_IMPL_MASK;
				PERIPHERAL_IRQ_ENABLE_IDX:  st_nxt.ena = wdat & PERIPH_IMPL_MASK;
				EDGE_CONFIG_IDX:            st_nxt.edge_cfg = wdat;
				PIN_CHANGE_SELECT_REG_IDX:
					st_nxt.pin_sel = wdat[PIN_COUNT-1:0] & PIN_SELECT_MASK[PIN_COUNT-1:0];
				CORE_STATUS_IDX: ;
				default: st_nxt.pslverr = 1'b1;
			endcase
		end else begin
			st_nxt.gie_block = 1'b0;
		end

		st_nxt.ctrl = st_nxt.ctrl | ctrl_set;
		st_nxt.req  = st_nxt.req | (req_set & PERIPH_IMPL_MASK);

		if (core_in.return_from_irq_instr)
			st_nxt.ctrl[GLOBAL_IRQ_ENABLE_BIT] = 1'b1;

		unique case (st_r.mode)
			MCUIC_RUN: begin
				if (pending && st_r.ctrl[GLOBAL_IRQ_ENABLE_BIT] && !st_r.gie_block
					&& !core_in.return_from_irq_instr) begin
					st_nxt.mode     = MCUIC_WAIT;
					st_nxt.wait_cnt = 2'h0;
				end else if (core_in.sleep_instr) begin
					st_nxt.mode      = MCUIC_SLEEP;
					st_nxt.wake_pend = 1'b0;
				end
			end
			MCUIC_WAIT: begin
				if (!st_r.ctrl[GLOBAL_IRQ_ENABLE_BIT]) begin
					st_nxt.mode = MCUIC_RUN;
				end else if (core_in.instr_end && st_r.phase == PHASE_Q4 && phase_tick) begin
					if (st_r.wait_cnt == ENTRY_WAIT_CYCLES)
						st_nxt.mode = MCUIC_ENTER;
					else
						st_nxt.wait_cnt = st_r.wait_cnt + 2'h1;
				end
			end
			MCUIC_ENTER: begin
				st_nxt.ctrl[GLOBAL_IRQ_ENABLE_BIT] = 1'b0;
				st_nxt.irq_take   = 1'b1;
				st_nxt.push_pc    = 1'b1;
				st_nxt.push_value = return_pc;
				st_nxt.mode       = MCUIC_RUN;
			end
			MCUIC_SLEEP: begin
				if (pending) begin
					st_nxt.wake_core = 1'b1;
					st_nxt.wake_pend = 1'b1;
					st_nxt.mode      = MCUIC_RUN;
				end
			end
		endcase
		st_nxt.asleep = (st_nxt.mode == MCUIC_SLEEP);
	end

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			st_r            <= '0;
			st_r.ctrl       <= CORE_IRQ_CONTROL_RST;
			st_r.req        <= PERIPH_REQUEST_RST;
			st_r.ena        <= PERIPH_ENABLE_RST;
			st_r.edge_cfg   <= EDGE_CONFIG_RST;
			st_r.pin_sel    <= PIN_SELECT_RST[PIN_COUNT-1:0];
			st_r.mode       <= MCUIC_RUN;
			st_r.vector     <= IRQ_VECTOR;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign prdata      = st_r.prdata;
	assign pready      = st_r.pready;
	assign pslverr     = st_r.pslverr;
	assign irq_take    = st_r.irq_take;
	assign vector_pc   = st_r.vector;
	assign push_pc     = st_r.push_pc;
	assign push_value  = st_r.push_value;
	assign wake_core   = st_r.wake_core;
	assign core_asleep = st_r.asleep;
	assign instr_phase = st_r.phase;

endmodule : mcuic_top

// [sim/mcuic_core_model.sv]
`timescale 1ns/1ps

module mcuic_core_model import mcuic_pkg::*; (
	input  wire logic       clk_sys,
	input  wire logic       nrst,
	input  wire logic [1:0] instr_phase,
	output logic            instr_end
);
	logic [7:0] q4_cnt_r;

	// ---------------------------------------------------------------
	// Instruction end on the last clock of Q4
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			q4_cnt_r <= 8'h00;
		end else if (instr_phase != PHASE_Q4) begin
			q4_cnt_r <= 8'h00;
		end else begin
			q4_cnt_r <= q4_cnt_r + 8'h01;
		end
	end

	assign instr_end = (instr_phase == PHASE_Q4) && (q4_cnt_r == PHASE_CYCLES - 8'h01);
endmodule : mcuic_core_model

// [sim/mcuic_top_props.sv]
`timescale 1ns/1ps

module mcuic_top_props import mcuic_pkg::*; #(
	parameter int PIN_COUNT = 6
) (
	input wire logic        clk_sys,
	input wire logic        nrst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [12:0] return_pc,
	input wire logic        irq_take,
	input wire logic [12:0] vector_pc,
	input wire logic        push_pc,
	input wire logic [12:0] push_value,
	input wire logic        wake_core,
	input wire logic        core_asleep,
	input wire logic [1:0]  instr_phase
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	// ---------------------------------------------------------------
	// Bus, interrupt entry, wake and instruction phase
	// ---------------------------------------------------------------
	sequence s_access_wait;
		psel && penable && !pready;
	endsequence
	sequence s_answer;
		pready ##1 !pready;
	endsequence

	a_apb_one_wait: assert property (s_access_wait |=> s_answer)
		else $error("bus answer not one cycle after access");
	a_err_reads_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
		else $error("refused read returned nonzero data");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("error flag without ready");
	a_take_vectors: assert property (irq_take |-> push_pc && vector_pc == IRQ_VECTOR)
		else $error("entry without push or wrong vector");
	a_push_only_pc: assert property (push_pc |-> push_value == $past(return_pc))
		else $error("pushed value is not the return address");
	a_wake_from_sleep: assert property (wake_core |-> $past(core_asleep))
		else $error("wake pulse while not asleep");
	a_take_when_awake: assert property (irq_take |-> !core_asleep)
		else $error("vector taken while asleep");
	a_phase_steps: assert property ($changed(instr_phase) |->
		instr_phase == 2'($past(instr_phase) + 2'h1))
		else $error("instruction phase skipped");
endmodule : mcuic_top_props

bind mcuic_top mcuic_top_props #(.PIN_COUNT(PIN_COUNT)) u_props (.clk_sys, .nrst, .psel,
	.penable, .pwrite, .prdata, .pready, .pslverr, .return_pc, .irq_take, .vector_pc,
	.push_pc, .push_value, .wake_core, .core_asleep, .instr_phase);

// [sim/test_mcuic_top.sv]
`timescale 1ns/1ps

module test_mcuic_top import mcuic_pkg::*;;
	localparam int          IC     = 4 * PHASE_CYCLES_INT;
	localparam logic [12:0] RET_PC = 13'h1a5c;
	// Row: write, index, data, expected read, expected error
	localparam logic [25:0] ROWS [13] = '{
		{1'b0, 8'h0b, 8'h00, 8'h00, 1'b0}, {1'b0, 8'h0c, 8'h00, 8'h00, 1'b0},
		{1'b0, 8'h8c, 8'h00, 8'h00, 1'b0}, {1'b0, 8'h81, 8'h00, 8'hff, 1'b0},
		{1'b0, 8'h96, 8'h00, 8'h00, 1'b0}, {1'b0, 8'h55, 8'h00, 8'h00, 1'b1},
		{1'b1, 8'h8c, 8'hff, 8'h00, 1'b0}, {1'b0, 8'h8c, 8'h00, 8'hef, 1'b0},
		{1'b1, 8'h0b, 8'h58, 8'h00, 1'b0}, {1'b0, 8'h8b, 8'h00, 8'h58, 1'b0},
		{1'b1, 8'h81, 8'hbf, 8'h00, 1'b0}, {1'b0, 8'h81, 8'h00, 8'hbf, 1'b0},
		{1'b1, 8'h55, 8'h12, 8'h00, 1'b1}};

	logic           clk_sys, nrst, psel, penable, pwrite, ext_irq_pin, pready, pslverr;
	logic           irq_take, push_pc, wake_core, core_asleep, instr_end, ret_instr, slp;
	logic [11:0]    paddr;
	logic [31:0]    pwdata, prdata;
	logic [12:0]    vector_pc, push_value;
	logic [1:0]     instr_phase;
	logic [5:0]     pins;
	logic [7:0]     rd;
	logic           er;
	mcuic_events_t  periph_events;
	mcuic_core_in_t core_in;
	int             num_errors, num_checks, takes, lat;

	assign core_in = {instr_end, ret_instr, slp, 1'b0};

	mcuic_top #(.PIN_COUNT(6)) u_dut (.clk_sys, .nrst, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .ext_irq_pin, .port_pins(pins), .periph_events,
		.core_in, .return_pc(RET_PC), .irq_take, .vector_pc, .push_pc, .push_value,
		.wake_core, .core_asleep, .instr_phase);
	mcuic_core_model u_core (.clk_sys, .nrst, .instr_phase, .instr_end);

	always @(posedge clk_sys) begin
		if (irq_take === 1'b1) takes <= takes + 1;
	end

	// ---------------------------------------------------------------
	// Tasks
	// ---------------------------------------------------------------
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic tally_and_finish;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : tally_and_finish

	task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {2'h0, idx, 2'h0};
		pwdata <= {24'h0, d};
		@(posedge clk_sys);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata[7:0];
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
		if (n >= 50) begin
			num_errors++;
			tally_and_finish();
		end
	endtask : apb

	// Bounded wait for the vector pulse or, with wake set, the wake pulse
	task automatic wait_sig(input logic wake, output int n);
		n = 0;
		while (((wake ? wake_core : irq_take) !== 1'b1) && n < 2000) begin
			@(posedge clk_sys);
			n++;
		end
		if (n >= 2000) begin
			num_errors++;
			tally_and_finish();
		end
	endtask : wait_sig

	task automatic pulse_timer1;
		periph_events.timer1_overflow <= 1'b1;
		@(posedge clk_sys);
		periph_events.timer1_overflow <= 1'b0;
	endtask : pulse_timer1

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	initial begin
		{nrst, psel, penable, pwrite, ret_instr, slp} = '0;
		{paddr, pwdata} = '0;
		periph_events = '0;
		ext_irq_pin = 1'b1;
		pins = '0;
		repeat (2) @(posedge clk_sys);
		nrst <= 1'b1;
		@(posedge clk_sys);
		foreach (ROWS[i]) begin
			apb(ROWS[i][25], ROWS[i][24:17], ROWS[i][16:9]);
			if (!ROWS[i][25]) check("rdata", 32'(rd), 32'(ROWS[i][8:1]));
			check("slverr", 32'(er), 32'(ROWS[i][0]));
		end
		// Flag sets with global enable off
		pulse_timer1();
		repeat (5) @(posedge clk_sys);
		apb(1'b0, 8'h0c, 8'h00);
		check("req", 32'(rd), 32'h01);
		check("takes", 32'(takes), 32'd0);
		apb(1'b1, 8'h0b, 8'hc8);
		wait_sig(1'b0, lat);
		check("push", 32'(push_value), 32'(RET_PC));
		apb(1'b0, 8'h0b, 8'h00);
		check("ctrl", 32'(rd), 32'h48);
		apb(1'b1, 8'h0c, 8'h00);
		ret_instr <= 1'b1;
		@(posedge clk_sys);
		ret_instr <= 1'b0;
		apb(1'b0, 8'h0b, 8'h00);
		check("ctrl", 32'(rd), 32'hc8);
		apb(1'b1, 8'h0b, 8'h48);
		pulse_timer1();
		repeat (100) @(posedge clk_sys);
		check("takes", 32'(takes), 32'd1);
		apb(1'b1, 8'h0b, 8'hc8);
		wait_sig(1'b0, lat);
		apb(1'b1, 8'h0c, 8'h00);
		// Falling edge selected, pin enable off
		apb(1'b1, 8'h0b, 8'h80);
		ext_irq_pin <= 1'b0;
		repeat (100) @(posedge clk_sys);
		apb(1'b0, 8'h0b, 8'h00);
		check("ctrl", 32'(rd), 32'h82);
		check("takes", 32'(takes), 32'd2);
		apb(1'b1, 8'h0b, 8'h90);
		ext_irq_pin <= 1'b1;
		repeat (100) @(posedge clk_sys);
		check("takes", 32'(takes), 32'd2);
		ext_irq_pin <= 1'b0;
		wait_sig(1'b0, lat);
		// Margin of four clocks for the pin synchroniser
		check("latency", 32'(lat >= 2 * IC && lat <= 4 * IC + 4), 32'd1);
		apb(1'b1, 8'h0b, 8'h10);
		slp <= 1'b1;
		@(posedge clk_sys);
		slp <= 1'b0;
		ext_irq_pin <= 1'b1;
		repeat (50) @(posedge clk_sys);
		check("asleep", 32'(core_asleep), 32'd1);
		ext_irq_pin <= 1'b0;
		wait_sig(1'b1, lat);
		repeat (200) @(posedge clk_sys);
		check("takes", 32'(takes), 32'd3);
		// Reset in mid-run clears the global enable
		apb(1'b1, 8'h0b, 8'h80);
		nrst <= 1'b0;
		repeat (2) @(posedge clk_sys);
		nrst <= 1'b1;
		@(posedge clk_sys);
		apb(1'b0, 8'h0b, 8'h00);
		check("ctrl", 32'(rd), 32'h00);
		// Pin change only on selected pins
		apb(1'b1, 8'h96, 8'h04);
		pins <= 6'h01;
		repeat (10) @(posedge clk_sys);
		apb(1'b0, 8'h0b, 8'h00);
		check("ctrl", 32'(rd), 32'h00);
		pins <= 6'h05;
		repeat (10) @(posedge clk_sys);
		apb(1'b0, 8'h0b, 8'h00);
		check("ctrl", 32'(rd), 32'h01);
		// Every periph_events source with all enables off
		periph_events <= '1;
		@(posedge clk_sys);
		periph_events <= '0;
		apb(1'b0, 8'h0c, 8'h00);
		check("req", 32'(rd), 32'hef);
		apb(1'b0, 8'h0b, 8'h00);
		check("ctrl", 32'(rd), 32'h05);
		// Event lands in the edge of a clearing write
		fork
			apb(1'b1, 8'h0c, 8'h00);
			begin
				@(posedge clk_sys);
				periph_events.timer2_match <= 1'b1;
				@(posedge clk_sys);
				periph_events.timer2_match <= 1'b0;
			end
		join
		apb(1'b0, 8'h0c, 8'h00);
		check("req", 32'(rd), 32'h02);
		tally_and_finish();
	end
endmodule : test_mcuic_top
